// ---- include/cms_pkg.sv ----
// Constants shared by the mailbox and semaphore block and its semaphore units.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses in an 8-bit window.
package cms_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int N_SEMA = 2;
	localparam int HOLDER_W = 3;
	localparam int REQ_W = 2;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MBOX_SET = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MBOX_CLEAR = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MBOX = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CONFIG = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_SEMAPHORE_ZERO_TAKE_TAKE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SEMAPHORE_ONE_TAKE_TAKE = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_SEMAPHORE_ZERO_TAKE_HOLDER = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_SEMAPHORE_ONE_TAKE_HOLDER = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_TRIGGER = 8'h20;

	// Interrupt configuration field positions
	localparam int CFG_POL0_BIT = 0;
	localparam int CFG_POL1_BIT = 1;
	localparam int CFG_ROUTE0_BIT = 2;
	localparam int CFG_ROUTE1_BIT = 3;
	localparam int CFG_W = 4;

	// Reset values
	localparam logic [DATA_W-1:0] MBOX_RESET = 32'h0000_0000;
	localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
	localparam logic [N_SEMA-1:0] TRIGGER_RESET = 2'h0;

	// Requester identities; the embedded core and PCIe share one code
	localparam logic [REQ_W-1:0] REQ_CORE_PCIE = 2'h0;
	localparam logic [REQ_W-1:0] REQ_PARALLEL = 2'h1;
	localparam logic [REQ_W-1:0] REQ_SERIAL = 2'h2;
	localparam logic [REQ_W-1:0] REQ_MGMT = 2'h3;

	// Holder codes: zero is free, otherwise requester code plus one
	localparam logic [HOLDER_W-1:0] HOLDER_FREE = 3'h0;

	// Take read answers and bus responses
	localparam logic [DATA_W-1:0] TAKE_OK = 32'h0000_0001;
	localparam logic [DATA_W-1:0] TAKE_FAIL = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cms_pkg

// ---- include/cms_sema_if.sv ----
// Carrier between the register front end and one semaphore unit.
// Assumes one clock; take and release are single-cycle pulses.
`timescale 1ns/1ps
interface cms_sema_if;
	import cms_pkg::*;
	logic take;
	logic release_req;
	logic [REQ_W-1:0] requester;
	logic free;
	logic [HOLDER_W-1:0] holder;
	modport ctl (output take, output release_req, output requester, input free, input holder);
	modport unit (input take, input release_req, input requester, output free, output holder);
endinterface : cms_sema_if

// ---- hdl/cms_sema.sv ----
// One hardware semaphore: holds the current holder code.
// Assumes take and release pulses come from the register front end on mclk.
`timescale 1ns/1ps
module cms_sema
	import cms_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	cms_sema_if.unit port
);
	logic [HOLDER_W-1:0] holder;

	// Release beats a take in the same cycle so a handshake release is never lost
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			holder <= HOLDER_FREE;
		end else if (port.release_req) begin
			holder <= HOLDER_FREE;
		end else if (port.take && holder == HOLDER_FREE) begin
			holder <= HOLDER_W'({1'b0, port.requester} + 3'h1);
		end
	end

	assign port.free = (holder == HOLDER_FREE);
	assign port.holder = holder;

	// A held semaphore ignores takes from anyone
	property p_held_stays;
		@(posedge mclk) disable iff (rst)
		(holder != HOLDER_FREE && !port.release_req) |=> $stable(holder);
	endproperty
	a_held_stays: assert property (p_held_stays) else $error("held semaphore changed");
endmodule : cms_sema

// ---- hdl/cms_top.sv ----
// Mailbox and two hardware semaphores for processor-to-processor signalling.
// Assumes an AXI4-Lite master on mclk that also drives its requester identity.
//
// How it works
// - One 32-bit mailbox, modifiable atomically by every requester.
// - Mailbox register reads the value; a write replaces its strobed bytes.
// - Clear-mask write clears exactly the masked bits in one update.
// - Set-mask write sets exactly the masked bits in one update.
// - Two semaphores with fully independent ownership.
// - Reading a take register attempts acquisition for the requester.
// - Holder register shows the resulting owner after a take read.
// - Any requester may release either semaphore, whoever holds it.
// - Only the four register bus requesters can be granted ownership.
// - Embedded core and PCIe count as one requester.
// - Each semaphore gives a soft interrupt for free or taken, polarity configurable.
// - Semaphore 0 drives soft interrupt zero, semaphore 1 drives line one.
// - A trigger register can force either soft interrupt.
// - Each soft interrupt routes to the core or to the external output.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cms_top
	import cms_pkg::*;
#(
	parameter int MBOX_W = DATA_W
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [REQ_W-1:0] requester_id,
	output logic [N_SEMA-1:0] cpu_soft_irq,
	output logic [N_SEMA-1:0] ext_soft_irq
);
	// Refused at elaboration: the mailbox is one bus word, set and cleared in one update
	if (MBOX_W != DATA_W) begin : g_bad_width
		$error("cms_top: MBOX_W must equal the bus width");
	end

	logic [DATA_W-1:0] mailbox;
	logic [CFG_W-1:0] semaphore_irq_config;
	logic [N_SEMA-1:0] irq_manual_trigger;
	logic aw_hold;
	logic w_hold;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W/8-1:0] wr_strb;
	logic [DATA_W-1:0] byte_mask;
	logic [DATA_W-1:0] wr_mask;
	logic write_fire;
	logic read_fire;
	logic [ADDR_W-1:0] wr_word;
	logic [ADDR_W-1:0] rd_word;
	logic [N_SEMA-1:0] take;
	logic [N_SEMA-1:0] release_req;
	logic [N_SEMA-1:0] sema_free;
	logic [HOLDER_W-1:0] sema_holder [N_SEMA];
	logic [N_SEMA-1:0] polarity;
	logic [N_SEMA-1:0] route_ext;
	logic [N_SEMA-1:0] soft_line;

	// Handshake decode; a write is performed only once both halves are held
	assign write_fire = aw_hold && w_hold && !s_axi_bvalid;
	assign read_fire = s_axi_arvalid && s_axi_arready;
	assign wr_word = {wr_addr[ADDR_W-1:2], 2'h0};
	assign rd_word = {s_axi_araddr[ADDR_W-1:2], 2'h0};
	assign wr_mask = wr_data & byte_mask;

	// Expand byte strobes so an unstrobed lane never touches the mailbox
	always_comb begin
		for (int i = 0; i < DATA_W / 8; i++) begin
			byte_mask[8*i +: 8] = {8{wr_strb[i]}};
		end
	end

	// Write address channel
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			aw_hold <= 1'b0;
			wr_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_hold <= 1'b1;
			wr_addr <= s_axi_awaddr;
		end else if (write_fire) begin
			s_axi_awready <= 1'b1;
			aw_hold <= 1'b0;
		end
	end

	// Write data channel, taken independently of the address
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_wready <= 1'b1;
			w_hold <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_hold <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (write_fire) begin
			s_axi_wready <= 1'b1;
			w_hold <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer SLVERR and change nothing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (write_fire) begin
			s_axi_bvalid <= 1'b1;
			case (wr_word)
				OFS_MBOX_SET, OFS_MBOX_CLEAR, OFS_MBOX, OFS_IRQ_CONFIG, OFS_SEMAPHORE_ZERO_TAKE_TAKE,
				OFS_SEMAPHORE_ONE_TAKE_TAKE, OFS_SEMAPHORE_ZERO_TAKE_HOLDER, OFS_SEMAPHORE_ONE_TAKE_HOLDER, OFS_IRQ_TRIGGER: begin
					s_axi_bresp <= RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Mailbox: one update per write, so set and clear masks are indivisible
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mailbox <= MBOX_RESET;
		end else if (write_fire) begin
			case (wr_word)
				OFS_MBOX_SET: begin
					mailbox <= mailbox | wr_mask;
				end
				OFS_MBOX_CLEAR: begin
					mailbox <= mailbox & ~wr_mask;
				end
				OFS_MBOX: begin
					mailbox <= (mailbox & ~byte_mask) | wr_mask;
				end
				default: begin
					mailbox <= mailbox;
				end
			endcase
		end
	end

	// Interrupt configuration and manual trigger, both plain read-write
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			semaphore_irq_config <= CFG_RESET;
			irq_manual_trigger <= TRIGGER_RESET;
		end else if (write_fire && wr_strb[0]) begin
			if (wr_word == OFS_IRQ_CONFIG) begin
				semaphore_irq_config <= wr_data[CFG_W-1:0];
			end
			if (wr_word == OFS_IRQ_TRIGGER) begin
				irq_manual_trigger <= wr_data[N_SEMA-1:0];
			end
		end
	end

	// Release from any requester; take on a take-register read
	assign release_req[0] = write_fire && wr_word == OFS_SEMAPHORE_ZERO_TAKE_TAKE && wr_strb[0] && wr_data[0];
	assign release_req[1] = write_fire && wr_word == OFS_SEMAPHORE_ONE_TAKE_TAKE && wr_strb[0] && wr_data[0];
	assign take[0] = read_fire && rd_word == OFS_SEMAPHORE_ZERO_TAKE_TAKE;
	assign take[1] = read_fire && rd_word == OFS_SEMAPHORE_ONE_TAKE_TAKE;

	// Separate units keep the two ownerships apart
	for (genvar g = 0; g < N_SEMA; g++) begin : g_sema
		cms_sema_if link ();
		assign link.take = take[g];
		assign link.release_req = release_req[g];
		// Only the four bus requester codes exist, core and PCIe already merged upstream
		assign link.requester = requester_id;
		assign sema_free[g] = link.free;
		assign sema_holder[g] = link.holder;
		cms_sema u_sema (
			.mclk(mclk),
			.rst(rst),
			.port(link.unit)
		);
	end

	// Read channel; the take answer reflects the state before this take
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (read_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (rd_word)
				OFS_MBOX_SET, OFS_MBOX_CLEAR, OFS_MBOX: begin
					s_axi_rdata <= mailbox;
				end
				OFS_IRQ_CONFIG: begin
					s_axi_rdata <= DATA_W'(semaphore_irq_config);
				end
				OFS_SEMAPHORE_ZERO_TAKE_TAKE: begin
					s_axi_rdata <= sema_free[0] ? TAKE_OK : TAKE_FAIL;
				end
				OFS_SEMAPHORE_ONE_TAKE_TAKE: begin
					s_axi_rdata <= sema_free[1] ? TAKE_OK : TAKE_FAIL;
				end
				OFS_SEMAPHORE_ZERO_TAKE_HOLDER: begin
					s_axi_rdata <= DATA_W'(sema_holder[0]);
				end
				OFS_SEMAPHORE_ONE_TAKE_HOLDER: begin
					s_axi_rdata <= DATA_W'(sema_holder[1]);
				end
				OFS_IRQ_TRIGGER: begin
					s_axi_rdata <= DATA_W'(irq_manual_trigger);
				end
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Soft interrupt lines: polarity 0 asserts while taken, 1 while free
	assign polarity = {semaphore_irq_config[CFG_POL1_BIT], semaphore_irq_config[CFG_POL0_BIT]};
	assign route_ext = {semaphore_irq_config[CFG_ROUTE1_BIT], semaphore_irq_config[CFG_ROUTE0_BIT]};
	always_comb begin
		for (int i = 0; i < N_SEMA; i++) begin
			soft_line[i] = (polarity[i] ? sema_free[i] : !sema_free[i]) || irq_manual_trigger[i];
		end
	end

	// Registered routing; a line goes to exactly one destination
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cpu_soft_irq <= '0;
			ext_soft_irq <= '0;
		end else begin
			cpu_soft_irq <= soft_line & ~route_ext;
			ext_soft_irq <= soft_line & route_ext;
		end
	end

	property p_mbox_set;
		@(posedge mclk) disable iff (rst)
		(write_fire && wr_word == OFS_MBOX_SET) |=> mailbox == ($past(mailbox) | $past(wr_mask));
	endproperty
	a_mbox_set: assert property (p_mbox_set) else $error("set mask wrong");

	property p_mbox_clear;
		@(posedge mclk) disable iff (rst)
		(write_fire && wr_word == OFS_MBOX_CLEAR) |=> mailbox == ($past(mailbox) & ~$past(wr_mask));
	endproperty
	a_mbox_clear: assert property (p_mbox_clear) else $error("clear mask wrong");

	property p_mbox_write;
		@(posedge mclk) disable iff (rst)
		(write_fire && wr_word == OFS_MBOX && &wr_strb) |=> mailbox == $past(wr_data);
	endproperty
	a_mbox_write: assert property (p_mbox_write) else $error("mailbox write lost");

	property p_take_ok;
		@(posedge mclk) disable iff (rst)
		(take[0] && !release_req[0] && sema_free[0]) |=>
			s_axi_rdata == TAKE_OK && sema_holder[0] == HOLDER_W'({1'b0, $past(requester_id)} + 3'h1);
	endproperty
	a_take_ok: assert property (p_take_ok) else $error("free take not granted");

	property p_take_fail;
		@(posedge mclk) disable iff (rst)
		(take[1] && !release_req[1] && !sema_free[1]) |=> s_axi_rdata == TAKE_FAIL && $stable(sema_holder[1]);
	endproperty
	a_take_fail: assert property (p_take_fail) else $error("held take changed owner");

	property p_release;
		@(posedge mclk) disable iff (rst)
		release_req[0] |=> sema_holder[0] == HOLDER_FREE && s_axi_bvalid;
	endproperty
	a_release: assert property (p_release) else $error("release did not free");

	property p_independent;
		@(posedge mclk) disable iff (rst)
		(take[0] && !release_req[1]) |=> $stable(sema_holder[1]);
	endproperty
	a_independent: assert property (p_independent) else $error("semaphores coupled");

	property p_irq_taken;
		@(posedge mclk) disable iff (rst)
		(!sema_free[0] && !polarity[0] && !route_ext[0]) |=> cpu_soft_irq[0] && !ext_soft_irq[0];
	endproperty
	a_irq_taken: assert property (p_irq_taken) else $error("taken irq missing");

	property p_force_ext;
		@(posedge mclk) disable iff (rst)
		(irq_manual_trigger[1] && route_ext[1]) |=> ext_soft_irq[1] && !cpu_soft_irq[1];
	endproperty
	a_force_ext: assert property (p_force_ext) else $error("forced irq not routed");
endmodule : cms_top

// ---- testbench/cms_cpu_model.sv ----
// Register bus master model standing for the CPUs on the core register bus.
// Assumes one task at a time is called, and that the slave samples on the rising edge of mclk.
`timescale 1ns/1ps
module cms_cpu_model
	import cms_pkg::*;
(
	input wire logic mclk,
	output logic [ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [DATA_W-1:0] s_axi_wdata,
	output logic [DATA_W/8-1:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready,
	output logic [REQ_W-1:0] requester_id
);
	// Quiet bus from time zero
	initial begin
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = '0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		requester_id = '0;
	end

	// Address and data go out together; data is scrambled once taken so stale values never match
	task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [DATA_W/8-1:0] s, output logic [1:0] r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wdata <= ~d;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : write

	// Identity is held with the address, since a take read acts for whoever asks
	task automatic read(input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] id,
		output logic [DATA_W-1:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		requester_id <= id;
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : read
endmodule : cms_cpu_model

// ---- testbench/tb_cpu_mailbox_semaphores.sv ----
// Self-checking bench for the mailbox and semaphore block against an integer model.
// Assumes the bus master model drives every bus input and the requester identity.
`timescale 1ns/1ps
module tb_cpu_mailbox_semaphores;
	import cms_pkg::*;
	logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, requester_id, cpu_soft_irq, ext_soft_irq;
	int error_cnt = 0;
	int n_tests = 0;
	int mbx, cfg, trig, d, op, st, m;
	int own[2];

	cms_top dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .requester_id(requester_id),
		.cpu_soft_irq(cpu_soft_irq), .ext_soft_irq(ext_soft_irq));

	cms_cpu_model cpu (.mclk(mclk), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .requester_id(requester_id));

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Counted comparison; case inequality so an unknown never passes
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// Line level is held state against polarity, forced level on top, then the chosen route
	function automatic logic [1:0] irq_exp(input int ext);
		logic [1:0] v;
		for (int i = 0; i < 2; i++)
			v[i] = (((own[i] != 0) ^ cfg[i]) | trig[i]) & (cfg[2+i] == ext);
		return v;
	endfunction : irq_exp

	task automatic irq_chk();
		repeat (2) @(posedge mclk);
		chk("cpu_soft_irq", irq_exp(0), cpu_soft_irq);
		chk("ext_soft_irq", irq_exp(1), ext_soft_irq);
	endtask : irq_chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
		logic [1:0] r;
		cpu.write(a, v, s, r);
		chk("bresp", (a > 8'h20) ? RESP_SLVERR : RESP_OKAY, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input int id, input logic [31:0] e, input string n);
		logic [31:0] v;
		logic [1:0] r;
		cpu.read(a, 2'(id), v, r);
		chk(n, e, v);
		chk("rresp", (a > 8'h20) ? RESP_SLVERR : RESP_OKAY, r);
	endtask : rd

	// A take succeeds only on a free semaphore and then records the asker
	task automatic take(input int s, input int id);
		int ok;
		ok = (own[s] == 0);
		if (ok)
			own[s] = id + 1;
		rd(OFS_SEMAPHORE_ZERO_TAKE_TAKE + 8'(4 * s), id, ok, "take");
	endtask : take

	// Watchdog, far beyond the several hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		$display("FAIL watchdog expected done seen hang");
		stop_test();
	end

	initial begin
		rst = 1'b1;
		mbx = 0;
		cfg = 0;
		trig = 0;
		own = '{0, 0};
		void'($urandom(32'h4ea7));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(OFS_MBOX, 0, MBOX_RESET, "mbox");
		rd(OFS_IRQ_CONFIG, 1, 0, "config");
		rd(OFS_IRQ_TRIGGER, 2, 0, "trigger");
		rd(OFS_SEMAPHORE_ZERO_TAKE_HOLDER, 3, 0, "holder0");
		rd(OFS_SEMAPHORE_ONE_TAKE_HOLDER, 0, 0, "holder1");
		irq_chk();
		$display("test reset done");
		// Random writes, set masks and clear masks on random byte lanes, read back by random askers
		for (int k = 0; k < 24; k++) begin
			d = $urandom;
			op = $urandom % 3;
			st = $urandom % 16;
			m = 0;
			for (int b = 0; b < 4; b++)
				if (st[b])
					m[8*b +: 8] = 8'hff;
			wr(8'(4 * op), d, 4'(st));
			d = d & m;
			mbx = (op == 0) ? (mbx | d) : (op == 1) ? (mbx & ~d) : ((mbx & ~m) | d);
			rd(8'(4 * ($urandom % 3)), $urandom % 4, mbx, "mailbox");
		end
		$display("test mailbox done");
		// Each asker on each semaphore, a refused take, the other one taken alongside
		for (int s = 0; s < 2; s++) begin
			for (int id = 0; id < 4; id++) begin
				take(s, id);
				take(s, (id + 1) % 4);
				take(1 - s, 3 - id);
				rd(OFS_SEMAPHORE_ZERO_TAKE_HOLDER + 8'(4 * s), id, id + 1, "holder");
				rd(OFS_SEMAPHORE_ONE_TAKE_HOLDER - 8'(4 * s), id, 4 - id, "other holder");
				irq_chk();
				wr(OFS_SEMAPHORE_ZERO_TAKE_TAKE + 8'(4 * s), 1);
				own[s] = 0;
				rd(OFS_SEMAPHORE_ZERO_TAKE_HOLDER + 8'(4 * s), 3 - id, 0, "released");
				rd(OFS_SEMAPHORE_ONE_TAKE_HOLDER - 8'(4 * s), id, 4 - id, "other kept");
				wr(OFS_SEMAPHORE_ONE_TAKE_TAKE - 8'(4 * s), 1);
				own[1 - s] = 0;
				irq_chk();
			end
		end
		$display("test semaphores done");
		// Every polarity and route with one semaphore held, forced levels on top
		take(0, 2);
		for (int c = 0; c < 16; c++) begin
			cfg = c;
			wr(OFS_IRQ_CONFIG, c);
			for (int t = 0; t < 4; t++) begin
				trig = t;
				wr(OFS_IRQ_TRIGGER, t);
				irq_chk();
			end
		end
		$display("test interrupts done");
		// Unmapped place refused, mailbox untouched
		wr(8'h24, 32'hffff_ffff);
		rd(8'h24, 1, 0, "unmapped");
		rd(OFS_MBOX, 2, mbx, "mbox kept");
		$display("test unmapped done");
		stop_test();
	end
endmodule : tb_cpu_mailbox_semaphores
